// *** iapm_pkg.sv ***
// constants and carrier types for the io auto power manager
package iapm_pkg;
  localparam logic [2:0] FDC_STATUS_A = 3'h0;
  localparam logic [2:0] FDC_STATUS_B = 3'h1;
  localparam logic [2:0] DRIVE_OUTPUT_CONTROL = 3'h2;
  localparam logic [2:0] DATA_RATE_SELECT = 3'h4;
  localparam logic [2:0] MAIN_STATUS = 3'h4;
  localparam logic [2:0] FIFO_DATA = 3'h5;
  localparam logic [2:0] DRIVE_INPUT_STATUS = 3'h7;
  localparam logic [2:0] RATE_CONFIGURATION = 3'h7;
  // configuration bit positions
  localparam int FDC_POWER_BIT = 3;
  localparam int PAR_POWER_BIT = 2;
  localparam int AUTO_FDC_BIT = 7;
  localparam int AUTO_PAR_BIT = 4;
  localparam int AUTO_SER1_BIT = 5;
  localparam int AUTO_SER2_BIT = 6;
  localparam int SER1_POWER_BIT = 3;
  localparam int SER2_POWER_BIT = 7;
  // drive output control fields
  localparam int DOC_MOTOR_LO = 4;
  localparam int DOC_RESET_N_BIT = 2;
  // data rate select fields
  localparam int DRS_RESET_BIT = 7;
  localparam int DRS_POWERDOWN_BIT = 6;
  localparam logic [7:0] MAIN_STATUS_IDLE = 8'h80;
  localparam logic [7:0] DOC_RESET = 8'h00;
  localparam logic [7:0] DRS_RESET = 8'h02;
  // extended control mode codes
  localparam logic [2:0] ECR_EPP = 3'h4;
  localparam logic [2:0] ECR_ECP = 3'h3;
  // timing
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int FDC_PD_TIME_MS = 10;
  localparam int FDC_PD_CYCLES = FDC_PD_TIME_MS * CLK_FREQ_KHZ;
  localparam int TIMER_W = 18;

  typedef enum logic [0:0] {
    FDC_RUN = 1'b0,
    FDC_AUTO_PD = 1'b1
  } iapm_fdc_state_type;

  typedef struct packed {
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic [7:0] main_status;
    logic [7:0] fifo_rdata;
    logic [7:0] drive_input;
    logic interrupt;
    logic head_unload_expired;
  } iapm_fdc_core_type;

  typedef struct packed {
    logic motor_on_0_n;
    logic drive_select_0_n;
    logic step_direction_n;
    logic step_pulse_n;
    logic write_data_out_n;
    logic write_gate_n;
    logic head_select_n;
    logic [1:0] density_select;
  } iapm_fdd_out_type;

  typedef struct packed {
    logic read_data_in_n;
    logic write_protect_in_n;
    logic track_zero_in_n;
    logic index_pulse_in_n;
    logic disk_change_in_n;
  } iapm_fdd_in_type;

  typedef struct packed {
    logic tx_buf_empty;
    logic tx_shift_empty;
    logic rx_fifo_empty;
    logic rx_wait_start;
    logic tx_buf_write;
  } iapm_uart_type;
endpackage

// *** iapm_power_manager.sv ***
// power manager for floppy, two serial ports and parallel port
`timescale 1ns/10ps
// Operation
// - fdc config bit 3 directly powers the floppy controller down
// - floppy auto powerdown only while auto enable bit 7 is set
// - enter auto powerdown: motors off, idle status, no irq, timers done
// - powerdown timer starts once auto powerdown is enabled
// - clearing the enable stops the timer and keeps the part awake
// - data-rate powerdown overrides auto powerdown; auto resumes afterwards
// - reset wakes with a reset sequence; access wake preserves all state
// - wake on motor enable, main status read, data read or write
// - after waking the 10 ms timer restarts
// - other accesses keep powerdown; reads true, writes retained
// - control writes wake only on motor bits set or a software reset (drive output bit 2 clear, data rate bit 7 set)
// - host side pins keep working during powerdown
// - tristate motor, select, write data, write gate; others stay active
// - serial power configuration directly powers the ports down
// - transmitter sleeps when buffer and shift register are empty
// - receiver sleeps when fifo empty and awaiting a start bit
// - ring indicator change stays visible while powered down
// - buffer write wakes transmitter; receive line change wakes receiver
// - parallel config bit 2 directly powers the parallel port down
// - epp and ecp auto powerdown only while enable bit 4 is set
// - epp logic sleeps when disabled or not selected in ecp mode
// - ecp logic sleeps when disabled or another mode is selected
module iapm_power_manager import iapm_pkg::*; #(
  parameter int PD_CYCLES = FDC_PD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_fdc_addr,
  input wire logic i_fdc_rd,
  input wire logic i_fdc_wr,
  input wire logic [7:0] i_fdc_wdata,
  output logic [7:0] o_fdc_rdata,
  input wire iapm_fdc_core_type i_fdc_core,
  input wire logic [7:0] i_fdc_logical_config,
  input wire logic [7:0] i_parallel_power_config,
  input wire logic [7:0] i_serial_power_config,
  input wire logic [7:0] i_auto_powerdown_enables,
  input wire iapm_fdd_out_type i_fdd_core_out,
  input wire iapm_fdd_in_type i_fdd_pins,
  input wire iapm_uart_type [1:0] i_uart,
  input wire logic [1:0] i_serial_receive_in,
  input wire logic [1:0] i_ring_indicator,
  input wire logic i_epp_enabled,
  input wire logic i_ecp_enabled,
  input wire logic [2:0] i_ecr_mode,
  output logic [7:0] o_drive_output_control,
  output logic [7:0] o_data_rate_select,
  output logic [7:0] o_rate_configuration,
  output logic o_fifo_wr,
  output logic o_fifo_rd,
  output logic [7:0] o_fifo_wdata,
  output logic o_fdc_soft_reset,
  output logic o_fdc_powered_down,
  output logic o_fdc_auto_powered_down,
  output iapm_fdd_out_type o_fdd_pins,
  output logic [3:0] o_fdd_pins_oe_n,
  output iapm_fdd_in_type o_fdd_in_sync,
  output logic [1:0] o_tx_powered_down,
  output logic [1:0] o_rx_powered_down,
  output logic [1:0] o_ring_change,
  output logic [1:0] o_serial_powered_down,
  output logic o_parallel_powered_down,
  output logic o_epp_powered_down,
  output logic o_ecp_powered_down
);

  typedef struct packed {
    iapm_fdc_state_type fdc_state;
    logic [TIMER_W-1:0] timer;
    logic timer_done;
    logic dsr_pd;
    logic fdc_pd;
    logic soft_reset;
    logic [7:0] doc;
    logic [7:0] drs;
    logic [7:0] rate_configuration;
    logic [7:0] rdata;
    logic fifo_wr;
    logic fifo_rd;
    logic [7:0] fifo_wdata;
    iapm_fdd_out_type fdd;
    logic [3:0] fdd_oe_n;
    iapm_fdd_in_type fdd_s1;
    iapm_fdd_in_type fdd_s2;
    logic [1:0] rxd_s1;
    logic [1:0] rxd_s2;
    logic [1:0] rxd_last;
    logic [1:0] ri_s1;
    logic [1:0] ri_s2;
    logic [1:0] ri_last;
    logic [1:0] ri_change;
    logic [1:0] tx_pd;
    logic [1:0] rx_pd;
    logic [1:0] ser_pd;
    logic par_pd;
    logic epp_pd;
    logic ecp_pd;
  } iapm_state_type;

  localparam logic [TIMER_W-1:0] TIMER_LAST =
    TIMER_W'(PD_CYCLES - 1);

  iapm_state_type st;
  iapm_state_type next_st;

  // decode of one fdc register access at a given offset
  function automatic logic hit(input logic [2:0] addr,
                               input logic [2:0] offset);
    hit = (addr == offset);
  endfunction

  logic auto_fdc_en;
  logic direct_fdc_pd;
  logic sw_reset_wr;
  logic motor_wr;
  logic access_wake;
  logic fdc_idle;
  logic [1:0] ser_auto_en;
  logic [1:0] ser_direct_pd;
  logic par_auto_en;

  always_comb begin
    auto_fdc_en = i_auto_powerdown_enables[AUTO_FDC_BIT];
    // config bit clear means the floppy block is switched off
    direct_fdc_pd = ~i_fdc_logical_config[FDC_POWER_BIT];
    ser_auto_en[0] = i_auto_powerdown_enables[AUTO_SER1_BIT];
    ser_auto_en[1] = i_auto_powerdown_enables[AUTO_SER2_BIT];
    ser_direct_pd[0] = ~i_serial_power_config[SER1_POWER_BIT];
    ser_direct_pd[1] = ~i_serial_power_config[SER2_POWER_BIT];
    par_auto_en = i_auto_powerdown_enables[AUTO_PAR_BIT];
    // writes that wake: motor bits or a software reset bit
    motor_wr = i_fdc_wr & hit(i_fdc_addr, DRIVE_OUTPUT_CONTROL)
      & (|i_fdc_wdata[7:DOC_MOTOR_LO]);
    sw_reset_wr = i_fdc_wr & (
      (hit(i_fdc_addr, DRIVE_OUTPUT_CONTROL)
        & ~i_fdc_wdata[DOC_RESET_N_BIT])
      | (hit(i_fdc_addr, DATA_RATE_SELECT)
        & i_fdc_wdata[DRS_RESET_BIT]));
    // reading drive output control is deliberately not a wake source
    access_wake = motor_wr
      | (i_fdc_rd & hit(i_fdc_addr, MAIN_STATUS))
      | ((i_fdc_rd | i_fdc_wr) & hit(i_fdc_addr, FIFO_DATA));
    fdc_idle = (st.doc[7:DOC_MOTOR_LO] == 4'h0)
      & (i_fdc_core.main_status == MAIN_STATUS_IDLE)
      & ~i_fdc_core.interrupt
      & i_fdc_core.head_unload_expired;
  end

  always_comb begin
    next_st = st;
    next_st.soft_reset = 1'b0;
    next_st.fifo_wr = 1'b0;
    next_st.fifo_rd = 1'b0;

    // reset first, so a powerdown bit in the same write still wins
    if (sw_reset_wr) begin
      next_st.soft_reset = 1'b1;
      next_st.dsr_pd = 1'b0;
    end

    // register writes are always stored, awake or not
    if (i_fdc_wr) begin
      case (i_fdc_addr)
        DRIVE_OUTPUT_CONTROL: begin
          next_st.doc = i_fdc_wdata;
        end
        DATA_RATE_SELECT: begin
          next_st.drs = i_fdc_wdata;
          if (i_fdc_wdata[DRS_POWERDOWN_BIT]) begin
            next_st.dsr_pd = 1'b1;
          end
        end
        FIFO_DATA: begin
          next_st.fifo_wr = 1'b1;
          next_st.fifo_wdata = i_fdc_wdata;
        end
        RATE_CONFIGURATION: begin
          next_st.rate_configuration = i_fdc_wdata;
        end
        default: begin
        end
      endcase
    end

    // reads show live status even while asleep
    if (i_fdc_rd) begin
      case (i_fdc_addr)
        FDC_STATUS_A: next_st.rdata = i_fdc_core.status_a;
        FDC_STATUS_B: next_st.rdata = i_fdc_core.status_b;
        DRIVE_OUTPUT_CONTROL: next_st.rdata = st.doc;
        MAIN_STATUS: next_st.rdata = i_fdc_core.main_status;
        FIFO_DATA: begin
          next_st.rdata = i_fdc_core.fifo_rdata;
          next_st.fifo_rd = 1'b1;
        end
        DRIVE_INPUT_STATUS: next_st.rdata = i_fdc_core.drive_input;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // counter on the host clock; restarts on any wake or disable
    if (!auto_fdc_en || next_st.dsr_pd || access_wake
        || sw_reset_wr) begin
      next_st.timer = '0;
      next_st.timer_done = 1'b0;
    end else if (st.fdc_state == FDC_RUN && !st.timer_done) begin
      if (st.timer == TIMER_LAST) begin
        next_st.timer_done = 1'b1;
      end else begin
        next_st.timer = st.timer + 1'b1;
      end
    end

    case (st.fdc_state)
      FDC_RUN: begin
        if (auto_fdc_en && !next_st.dsr_pd && st.timer_done
            && fdc_idle && !access_wake && !sw_reset_wr) begin
          next_st.fdc_state = FDC_AUTO_PD;
        end
      end
      FDC_AUTO_PD: begin
        // access wake keeps every register as it was
        if (!auto_fdc_en || access_wake || sw_reset_wr
            || next_st.dsr_pd) begin
          next_st.fdc_state = FDC_RUN;
        end
      end
      default: next_st.fdc_state = FDC_RUN;
    endcase

    next_st.fdc_pd = direct_fdc_pd | next_st.dsr_pd
      | (next_st.fdc_state == FDC_AUTO_PD);

    // drive pins: tristate the drive-facing strobes when asleep
    next_st.fdd = i_fdd_core_out;
    next_st.fdd_oe_n = {4{next_st.fdc_pd}};

    // synchronisers for pins from outside the clock domain
    next_st.fdd_s1 = i_fdd_pins;
    next_st.fdd_s2 = st.fdd_s1;
    next_st.rxd_s1 = i_serial_receive_in;
    next_st.rxd_s2 = st.rxd_s1;
    next_st.rxd_last = st.rxd_s2;
    next_st.ri_s1 = i_ring_indicator;
    next_st.ri_s2 = st.ri_s1;
    next_st.ri_last = st.ri_s2;

    for (int p = 0; p < 2; p++) begin
      next_st.ser_pd[p] = ser_direct_pd[p];
      // ring change is tracked regardless of power state
      next_st.ri_change[p] = st.ri_s2[p] ^ st.ri_last[p];
      if (!ser_auto_en[p] || i_uart[p].tx_buf_write) begin
        next_st.tx_pd[p] = 1'b0;
      end else if (i_uart[p].tx_buf_empty
                   && i_uart[p].tx_shift_empty) begin
        next_st.tx_pd[p] = 1'b1;
      end else begin
        next_st.tx_pd[p] = 1'b0;
      end
      if (!ser_auto_en[p] || (st.rxd_s2[p] ^ st.rxd_last[p])) begin
        next_st.rx_pd[p] = 1'b0;
      end else if (i_uart[p].rx_fifo_empty
                   && i_uart[p].rx_wait_start) begin
        next_st.rx_pd[p] = 1'b1;
      end else begin
        next_st.rx_pd[p] = 1'b0;
      end
    end

    // parallel port, re-evaluated every cycle so mode changes apply
    next_st.par_pd = ~i_parallel_power_config[PAR_POWER_BIT];
    next_st.epp_pd = par_auto_en & (~i_epp_enabled
      | (i_ecp_enabled & (i_ecr_mode != ECR_EPP)));
    next_st.ecp_pd = par_auto_en & (~i_ecp_enabled
      | (i_ecr_mode != ECR_ECP));
  end

  // synchronous reset gives the normal reset sequence
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.doc <= DOC_RESET;
      st.drs <= DRS_RESET;
      st.fdd <= '1;
      st.fdd_oe_n <= 4'hf;
      st.fdd_s1 <= '1;
      st.fdd_s2 <= '1;
      st.rxd_s1 <= 2'h3;
      st.rxd_s2 <= 2'h3;
      st.rxd_last <= 2'h3;
      // idle pin level, so no false ring edge follows reset
      st.ri_s1 <= 2'h3;
      st.ri_s2 <= 2'h3;
      st.ri_last <= 2'h3;
      st.fdc_state <= FDC_RUN;
    end else begin
      st <= next_st;
    end
  end

  // host interface pins are never gated by powerdown
  always_comb begin
    o_fdc_rdata = st.rdata;
    o_drive_output_control = st.doc;
    o_data_rate_select = st.drs;
    o_rate_configuration = st.rate_configuration;
    o_fifo_wr = st.fifo_wr;
    o_fifo_rd = st.fifo_rd;
    o_fifo_wdata = st.fifo_wdata;
    o_fdc_soft_reset = st.soft_reset;
    o_fdc_powered_down = st.fdc_pd;
    o_fdc_auto_powered_down = (st.fdc_state == FDC_AUTO_PD);
    o_fdd_pins = st.fdd;
    o_fdd_pins_oe_n = st.fdd_oe_n;
    o_fdd_in_sync = st.fdd_s2;
    o_tx_powered_down = st.tx_pd;
    o_rx_powered_down = st.rx_pd;
    o_ring_change = st.ri_change;
    o_serial_powered_down = st.ser_pd;
    o_parallel_powered_down = st.par_pd;
    o_epp_powered_down = st.epp_pd;
    o_ecp_powered_down = st.ecp_pd;
  end

endmodule

// *** iapm_power_manager_assertions.sv ***
// assertion checker for the io auto power manager
`timescale 1ns/10ps
module iapm_power_manager_assertions import iapm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_fdc_addr,
  input wire logic i_fdc_rd,
  input wire logic i_fdc_wr,
  input wire iapm_fdc_core_type i_fdc_core,
  input wire logic [7:0] i_fdc_logical_config,
  input wire logic [7:0] i_parallel_power_config,
  input wire logic [7:0] i_auto_powerdown_enables,
  input wire logic [7:0] o_fdc_rdata,
  input wire logic o_fdc_powered_down,
  input wire logic o_fdc_auto_powered_down,
  input wire logic [3:0] o_fdd_pins_oe_n,
  input wire logic o_parallel_powered_down
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire en = i_auto_powerdown_enables[AUTO_FDC_BIT];
  wire apd = o_fdc_auto_powered_down;
  wire hit = i_fdc_rd | i_fdc_wr;
  property p_direct;
    !i_fdc_logical_config[FDC_POWER_BIT] |=> o_fdc_powered_down;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct powerdown not shown");
  property p_auto_off;
    !en [*2] |=> !apd;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("auto powerdown while disabled");
  // two busy cycles cover either output latency of the entry path
  property p_irq;
    i_fdc_core.interrupt [*2] |=> !$rose(apd);
  endproperty
  a_irq: assert property (p_irq)
    else $error("auto powerdown entered with interrupt high");
  property p_status_wake;
    apd && i_fdc_rd && i_fdc_addr == MAIN_STATUS |-> ##[1:2] !apd;
  endproperty
  a_status_wake: assert property (p_status_wake)
    else $error("main status read did not wake");
  property p_data_wake;
    apd && hit && i_fdc_addr == FIFO_DATA |-> ##[1:2] !apd;
  endproperty
  a_data_wake: assert property (p_data_wake)
    else $error("data access did not wake");
  property p_stay;
    !hit && en ##1 apd && en && i_fdc_rd && i_fdc_addr == FDC_STATUS_A
      |=> apd;
  endproperty
  a_stay: assert property (p_stay)
    else $error("status read woke the part");
  property p_rdata;
    i_fdc_rd && i_fdc_addr == FDC_STATUS_A
      |=> o_fdc_rdata == $past(i_fdc_core.status_a);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("status read not true");
  property p_oe;
    o_fdc_powered_down [*2] |-> o_fdd_pins_oe_n == 4'hf;
  endproperty
  a_oe: assert property (p_oe)
    else $error("drive pins driven in powerdown");
  property p_par;
    !i_parallel_power_config[PAR_POWER_BIT] |=> o_parallel_powered_down;
  endproperty
  a_par: assert property (p_par)
    else $error("parallel direct powerdown not shown");
endmodule
bind iapm_power_manager iapm_power_manager_assertions u_chk (.*);

// *** iapm_core_model.sv ***
// floppy core stand-in: fixed status, idle main status, stepping outputs
`timescale 1ns/10ps
module iapm_core_model import iapm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_irq,
  output iapm_fdc_core_type o_core,
  output iapm_fdd_out_type o_fdd
);
  logic step_n = 1'b1;
  // step toggles every cycle so a frozen pin copy is visible
  always @(posedge i_clk) begin
    step_n <= !step_n;
  end
  assign o_core = {8'h3c, 8'hc3, MAIN_STATUS_IDLE, 8'h96, 8'h81, i_irq, 1'b1};
  assign o_fdd = {3'b111, step_n, 3'b111, 2'b01};
endmodule

// *** tb_iapm_power_manager.sv ***
// self-checking testbench for the io auto power manager
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_iapm_power_manager import iapm_pkg::*;;
  // short timer keeps the run brief
  localparam int PD = 20;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  int m;
  int k;
  logic [2:0] p;
  logic o_fifo_wr, o_fifo_rd, o_fdc_soft_reset;
  logic [7:0] o_rate_configuration;
  iapm_fdd_in_type o_fdd_in_sync;
  logic i_clk = 1'b0, i_rst = 1'b1, i_fdc_rd = 1'b0, i_fdc_wr = 1'b0;
  logic i_epp_enabled = 1'b0, i_ecp_enabled = 1'b0, irq = 1'b0, s;
  logic [2:0] i_fdc_addr = 3'h0, i_ecr_mode = 3'h0;
  logic [7:0] i_fdc_wdata = 8'h00, i_fdc_logical_config = 8'h08;
  logic [7:0] i_parallel_power_config = 8'h04, i_serial_power_config = 8'h88;
  logic [7:0] i_auto_powerdown_enables = 8'h00, o_fdc_rdata, d;
  logic [7:0] o_drive_output_control, o_data_rate_select, o_fifo_wdata;
  logic [1:0] i_serial_receive_in = 2'b11, i_ring_indicator = 2'b11;
  logic [1:0] o_tx_powered_down, o_rx_powered_down, o_ring_change;
  logic [1:0] o_serial_powered_down;
  logic o_fdc_powered_down, o_fdc_auto_powered_down, o_parallel_powered_down;
  logic o_epp_powered_down, o_ecp_powered_down;
  logic [3:0] o_fdd_pins_oe_n;
  iapm_uart_type [1:0] i_uart = {2{5'b11110}};
  iapm_fdc_core_type i_fdc_core;
  iapm_fdd_out_type i_fdd_core_out, o_fdd_pins;
  iapm_fdd_in_type i_fdd_pins = 5'h1f;
  wire apd = o_fdc_auto_powered_down;
  iapm_core_model i_core (.i_clk(i_clk), .i_irq(irq), .o_core(i_fdc_core),
    .o_fdd(i_fdd_core_out));
  iapm_power_manager #(.PD_CYCLES(PD)) i_dut (.*);
  initial begin
    forever #20 i_clk = !i_clk;
  end
  task automatic cyc(int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic acc(logic w, logic [2:0] a, logic [7:0] v);
    @(posedge i_clk);
    i_fdc_addr <= a;
    i_fdc_wdata <= v;
    i_fdc_wr <= w;
    i_fdc_rd <= !w;
    @(posedge i_clk);
    i_fdc_rd <= 1'b0;
    i_fdc_wr <= 1'b0;
    @(negedge i_clk);
    d = o_fdc_rdata;
    p = {o_fifo_wr, o_fifo_rd, o_fdc_soft_reset};
  endtask
  task automatic wait_apd();
    n = 0;
    while (apd !== 1'b1 && n < PD + 10) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_direct;
    `CHK("drive output reset", DOC_RESET, o_drive_output_control)
    `CHK("data rate reset", DRS_RESET, o_data_rate_select)
    `CHK("pins driven", 4'h0, o_fdd_pins_oe_n)
    @(posedge i_clk);
    i_fdc_logical_config <= 8'h00;
    i_parallel_power_config <= 8'h00;
    i_serial_power_config <= 8'h08;
    cyc(3);
    `CHK("fdc direct", 1'b1, o_fdc_powered_down)
    `CHK("fdc pins off", 4'hf, o_fdd_pins_oe_n)
    `CHK("parallel direct", 1'b1, o_parallel_powered_down)
    `CHK("serial direct", 2'b10, o_serial_powered_down)
    @(posedge i_clk);
    i_fdc_logical_config <= 8'h08;
    i_parallel_power_config <= 8'h04;
    i_serial_power_config <= 8'h88;
    cyc(3);
    `CHK("fdc up", 1'b0, o_fdc_powered_down)
    $display("direct test ended");
  endtask
  task automatic t_auto;
    @(posedge i_clk);
    irq <= 1'b1;
    i_auto_powerdown_enables <= 8'h80;
    cyc(PD + 8);
    `CHK("held by interrupt", 1'b0, apd)
    @(posedge i_clk);
    irq <= 1'b0;
    wait_apd();
    `CHK("idle entry", 1'b1, n <= 5)
    `CHK("drive pins off", 4'hf, o_fdd_pins_oe_n)
    @(posedge i_clk);
    i_fdd_pins <= 5'h0e;
    cyc(3);
    `CHK("drive inputs live", 5'h0e, o_fdd_in_sync)
    s = o_fdd_pins.step_pulse_n;
    cyc(1);
    `CHK("step still active", !s, o_fdd_pins.step_pulse_n)
    acc(1'b0, FDC_STATUS_A, 8'h00);
    `CHK("status a", 8'h3c, d)
    acc(1'b1, DRIVE_OUTPUT_CONTROL, 8'h04);
    acc(1'b1, DATA_RATE_SELECT, 8'h02);
    `CHK("stay down", 1'b1, apd)
    `CHK("write retained", 8'h04, o_drive_output_control)
    acc(1'b0, MAIN_STATUS, 8'h00);
    cyc(1);
    `CHK("main status", MAIN_STATUS_IDLE, d)
    `CHK("status read wake", 1'b0, apd)
    wait_apd();
    `CHK("timer restart", 1'b1, n >= PD - 3 && n <= PD + 3)
    acc(1'b1, DRIVE_OUTPUT_CONTROL, 8'h14);
    cyc(1);
    `CHK("motor wake", 1'b0, apd)
    acc(1'b1, DRIVE_OUTPUT_CONTROL, 8'h04);
    wait_apd();
    `CHK("motor off sleeps", 1'b1, apd)
    acc(1'b1, RATE_CONFIGURATION, 8'h01);
    `CHK("rate config kept", 8'h01, o_rate_configuration)
    `CHK("rate write no wake", 1'b1, apd)
    acc(1'b1, FIFO_DATA, 8'h69);
    `CHK("data write pulse", 3'b100, p)
    cyc(1);
    `CHK("data write wake", 1'b0, apd)
    `CHK("data passed on", 8'h69, o_fifo_wdata)
    wait_apd();
    acc(1'b0, FIFO_DATA, 8'h00);
    `CHK("data read", 8'h96, d)
    `CHK("data read pulse", 3'b010, p)
    `CHK("data read wake", 1'b0, apd)
    wait_apd();
    acc(1'b1, DRIVE_OUTPUT_CONTROL, 8'h00);
    `CHK("soft reset pulse", 3'b001, p)
    `CHK("soft reset wake", 1'b0, apd)
    @(posedge i_clk);
    i_auto_powerdown_enables <= 8'h00;
    cyc(PD + 8);
    `CHK("enable cleared", 1'b0, apd)
    $display("auto test ended");
  endtask
  task automatic t_serial;
    @(posedge i_clk);
    i_auto_powerdown_enables <= 8'h60;
    cyc(3);
    `CHK("tx asleep", 2'b11, o_tx_powered_down)
    `CHK("rx asleep", 2'b11, o_rx_powered_down)
    @(posedge i_clk);
    i_uart[0].tx_shift_empty <= 1'b0;
    i_uart[1].rx_wait_start <= 1'b0;
    i_ring_indicator[0] <= 1'b0;
    i_serial_receive_in[0] <= 1'b0;
    i_uart[1].tx_buf_write <= 1'b1;
    @(posedge i_clk);
    i_uart[1].tx_buf_write <= 1'b0;
    n = 0;
    m = 0;
    k = 0;
    repeat (6) begin
      @(negedge i_clk);
      n += o_ring_change[0];
      m += !o_rx_powered_down[0];
      k += !o_tx_powered_down[1];
    end
    `CHK("ring edges", 1, n)
    `CHK("rx line wake", 1, m)
    `CHK("tx write wake", 1, k)
    `CHK("tx awake", 2'b10, o_tx_powered_down)
    `CHK("rx awake", 2'b01, o_rx_powered_down)
    $display("serial test ended");
  endtask
  task automatic t_parallel;
    @(posedge i_clk);
    i_auto_powerdown_enables <= 8'h10;
    i_epp_enabled <= 1'b1;
    i_ecp_enabled <= 1'b1;
    i_ecr_mode <= ECR_EPP;
    cyc(2);
    `CHK("epp mode", 2'b01, {o_epp_powered_down, o_ecp_powered_down})
    @(posedge i_clk);
    i_ecr_mode <= ECR_ECP;
    cyc(2);
    `CHK("ecp mode", 2'b10, {o_epp_powered_down, o_ecp_powered_down})
    @(posedge i_clk);
    i_auto_powerdown_enables <= 8'h00;
    cyc(2);
    `CHK("auto off", 2'b00, {o_epp_powered_down, o_ecp_powered_down})
    $display("parallel test ended");
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    cyc(2);
    t_direct;
    t_auto;
    t_serial;
    t_parallel;
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    print_verdict;
  end
endmodule
